// File: src/tlb_sync_regs.svh
// Register offsets, field positions, reset values and counts for the translation result and TLB sync block
`ifndef TLB_SYNC_REGS_SVH
`define TLB_SYNC_REGS_SVH

// ==========================================
// Register byte offsets
`define OFF_RESULT_LO 8'h00
`define OFF_RESULT_HI 8'h04
`define OFF_SYNC_COMMAND 8'h08
`define OFF_SYNC_STATUS 8'h0C
`define OFF_ALIAS_COMMAND 8'h10
`define OFF_ALIAS_STATUS 8'h14

// ==========================================
// Result field positions, success layout
`define RES_ATTR_HI 63
`define RES_ATTR_LO 56
`define RES_ADDR_HI 39
`define RES_ADDR_LO 12
`define RES_IMPL_BIT 10
`define RES_SECATTR_BIT 9
`define RES_SHARE_HI 8
`define RES_SHARE_LO 7
`define RES_FAULT_BIT 0

// ==========================================
// Result field positions, fault layout
`define RES_LEVEL_HI 33
`define RES_LEVEL_LO 32
`define RES_MISSING_BIT 30
`define RES_INVCTX_BIT 29
`define RES_LOCK_BIT 6
`define RES_MULTI_BIT 5
`define RES_EXT_BIT 4
`define RES_PERM_BIT 3
`define RES_ACCFLAG_BIT 2
`define RES_MAPPING_BIT 1

// ==========================================
// Reset values and counts
`define RESULT_RESET 64'h0000_0000_0000_0000
`define STATUS_ACTIVE_BIT 0
`define PENDING_WIDTH 4
`define BANK_COUNT 2

`endif

// File: src/tlb_sync_pkg.sv
// Types shared by the translation result and TLB sync block
package tlb_sync_pkg;

	// ==========================================
	// Avalon-MM request carried as one bundle
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} bus_req_t;

	// ==========================================
	// Completed translation reported by the walker
	typedef struct packed {
		logic done;
		logic bank_secure;
		logic fault;
		logic [7:0] result_memory_attributes;
		logic [27:0] physical_address_field;
		logic security_attribute_bit;
		logic impl_defined_bit;
		logic [1:0] shareability_field;
		logic [1:0] walk_level;
		logic missing_bank_fault;
		logic invalid_context_flag;
		logic lock_fault_flag;
		logic multi_match_fault;
		logic external_fault_flag;
		logic permission_fault_flag;
		logic access_flag_error;
		logic mapping_fault_flag;
	} xlat_result_t;

	// ==========================================
	// TLB invalidate progress events, one bit per bank (1 = secure)
	typedef struct packed {
		logic [1:0] start;
		logic [1:0] done;
	} inval_event_t;

	// Per-bank synchronisation state
	typedef enum logic [0:0] {
		SYNC_IDLE,
		SYNC_DRAIN
	} sync_state_t;

endpackage

// File: src/translation_result_tlb_sync.sv
// Global translation result registers and global TLB invalidate synchronisation, banked by security state
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "tlb_sync_regs.svh"

module translation_result_tlb_sync
	import tlb_sync_pkg::*;
#(
	parameter int PEND_W = `PENDING_WIDTH
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Avalon-MM slave
	input wire bus_req_t bus_req,
	input wire logic bus_secure,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Translation walker results
	input wire xlat_result_t xlat,
	// TLB invalidate progress
	input wire inval_event_t inval,
	// Sync activity per bank, bit 1 secure
	output logic [1:0] sync_busy
);

	// ==========================================
	// Storage
	logic [63:0] result [`BANK_COUNT];
	logic [PEND_W-1:0] pending [`BANK_COUNT];
	logic [PEND_W-1:0] drain [`BANK_COUNT];
	sync_state_t sync_state [`BANK_COUNT];
	logic [1:0] active;
	logic [1:0] cmd_hit;
	logic [1:0] upd_ok;
	logic [1:0] upd_fault;
	logic bus_take;
	logic own_active;
	logic [31:0] next_readdata;

	// A request is taken on the edge where waitrequest is already low
	assign bus_take = (bus_req.read | bus_req.write) & ~waitrequest;

	// Activity of the copy that the current access selects, kept for the status check
	assign own_active = active[bus_secure];

	// ==========================================
	// Result formatting
	function automatic logic [63:0] format_result(input xlat_result_t r, input logic secure_bank);
		logic [63:0] v;
		v = `RESULT_RESET;
		if (r.fault)
		begin
			v[`RES_LEVEL_HI:`RES_LEVEL_LO] = r.walk_level;
			v[`RES_MISSING_BIT] = r.missing_bank_fault;
			v[`RES_INVCTX_BIT] = r.invalid_context_flag;
			v[`RES_LOCK_BIT] = r.lock_fault_flag;
			v[`RES_MULTI_BIT] = r.multi_match_fault;
			v[`RES_EXT_BIT] = r.external_fault_flag;
			v[`RES_PERM_BIT] = r.permission_fault_flag;
			v[`RES_ACCFLAG_BIT] = r.access_flag_error;
			v[`RES_MAPPING_BIT] = r.mapping_fault_flag;
			v[`RES_FAULT_BIT] = 1'b1;
		end
		else
		begin
			v[`RES_ATTR_HI:`RES_ATTR_LO] = r.result_memory_attributes;
			v[`RES_ADDR_HI:`RES_ADDR_LO] = r.physical_address_field;
			v[`RES_IMPL_BIT] = r.impl_defined_bit;
			// Non-secure copy never exposes the entry security attribute
			v[`RES_SECATTR_BIT] = secure_bank & r.security_attribute_bit;
			v[`RES_SHARE_HI:`RES_SHARE_LO] = r.shareability_field;
			v[`RES_FAULT_BIT] = 1'b0;
		end
		return v;
	endfunction

	// ==========================================
	// Command decode: own bank by access security, alias reaches non-secure copy
	always_comb
	begin
		cmd_hit = 2'b00;
		if (bus_take && bus_req.write)
		begin
			if (bus_req.address == `OFF_SYNC_COMMAND)
				cmd_hit[bus_secure] = 1'b1;
			else if (bus_req.address == `OFF_ALIAS_COMMAND && bus_secure)
				cmd_hit[0] = 1'b1;
		end
	end

	// ==========================================
	// Per-bank result copy, invalidate tracking and sync machine
	genvar b;
	generate
		for (b = 0; b < `BANK_COUNT; b++)
		begin : g_bank
			logic is_secure;
			assign is_secure = (b == 1);
			assign upd_ok[b] = xlat.done & (xlat.bank_secure == is_secure) & ~xlat.fault;
			assign upd_fault[b] = xlat.done & (xlat.bank_secure == is_secure) & xlat.fault;
			assign active[b] = (sync_state[b] == SYNC_DRAIN);

			// Latest translation outcome for this security state
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
					result[b] <= `RESULT_RESET;
				else if (xlat.done && xlat.bank_secure == is_secure)
					result[b] <= format_result(xlat, is_secure);
			end

			// Invalidates accepted but not finished; a stray completion is ignored
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
					pending[b] <= '0;
				else if (inval.start[b] && !(inval.done[b] && pending[b] != '0))
					pending[b] <= pending[b] + PEND_W'(1);
				else if (!inval.start[b] && inval.done[b] && pending[b] != '0)
					pending[b] <= pending[b] - PEND_W'(1);
			end

			// Sync drains only invalidates accepted before the command, assuming in-order completion
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
				begin
					sync_state[b] <= SYNC_IDLE;
					drain[b] <= '0;
				end
				else if (cmd_hit[b])
				begin
					// A repeated command snapshots again, which covers the older one too
					sync_state[b] <= SYNC_DRAIN;
					if (inval.done[b] && pending[b] != '0)
						drain[b] <= pending[b] - PEND_W'(1);
					else
						drain[b] <= pending[b];
				end
				else
				begin
					case (sync_state[b])
						SYNC_IDLE:
							drain[b] <= '0;
						SYNC_DRAIN:
						begin
							if (drain[b] == '0)
								sync_state[b] <= SYNC_IDLE;
							else if (inval.done[b])
								drain[b] <= drain[b] - PEND_W'(1);
						end
						default:
							sync_state[b] <= SYNC_IDLE;
					endcase
				end
			end
		end
	endgenerate

	// ==========================================
	// Read data selection; unmapped and write-only offsets read as zero
	always_comb
	begin
		next_readdata = 32'h0000_0000;
		case (bus_req.address)
			`OFF_RESULT_LO:
				next_readdata = result[bus_secure][31:0];
			`OFF_RESULT_HI:
				next_readdata = result[bus_secure][63:32];
			`OFF_SYNC_STATUS:
				next_readdata[`STATUS_ACTIVE_BIT] = active[bus_secure];
			`OFF_ALIAS_STATUS:
				next_readdata[`STATUS_ACTIVE_BIT] = bus_secure & active[0];
			default:
				next_readdata = 32'h0000_0000;
		endcase
	end

	// ==========================================
	// Bus handshake: one wait cycle, then a one-cycle acknowledge
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			waitrequest <= 1'b1;
		else if ((bus_req.read || bus_req.write) && waitrequest)
			waitrequest <= 1'b0;
		else
			waitrequest <= 1'b1;
	end

	// Read data is loaded together with the acknowledge and held afterwards
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			readdata <= 32'h0000_0000;
		else if (bus_req.read && waitrequest)
			readdata <= next_readdata;
	end

	// Registered copy of activity for hardware observers
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			sync_busy <= 2'b00;
		else
			sync_busy <= {(cmd_hit[1] | (active[1] & ~(drain[1] == '0))), (cmd_hit[0] | (active[0] & ~(drain[0] == '0)))};
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence status_read_s;
		bus_req.read && waitrequest && bus_req.address == `OFF_SYNC_STATUS;
	endsequence

	sequence secure_cmd_s;
		bus_req.write && !waitrequest && bus_secure && bus_req.address == `OFF_SYNC_COMMAND;
	endsequence

	sequence ns_cmd_s;
		bus_req.write && !waitrequest && !bus_secure && bus_req.address == `OFF_SYNC_COMMAND;
	endsequence

	sequence alias_cmd_s;
		bus_req.write && !waitrequest && bus_secure && bus_req.address == `OFF_ALIAS_COMMAND;
	endsequence

	// A non-secure master must never reach the alias
	sequence ns_alias_s;
		bus_req.write && !waitrequest && !bus_secure && bus_req.address == `OFF_ALIAS_COMMAND;
	endsequence

	// ==========================================
	// Success layout, both copies
	attr_top_byte_a: assert property (upd_ok[1] |=> result[1][63:56] == $past(xlat.result_memory_attributes))
		else $error("attribute byte not placed in bits 63:56");

	addr_field_a: assert property (upd_ok[1] |=> result[1][39:12] == $past(xlat.physical_address_field)
		&& result[1][55:40] == 16'h0000)
		else $error("address field or reserved bits wrong");

	secure_attr_a: assert property (upd_ok[1] |=> result[1][9] == $past(xlat.security_attribute_bit))
		else $error("secure copy lost security attribute");

	nonsec_reserved_a: assert property (upd_ok[0] |=> result[0][9] == 1'b0)
		else $error("non-secure copy exposed security attribute");

	share_field_a: assert property (upd_ok[0] |=> result[0][8:7] == $past(xlat.shareability_field)
		&& result[0][6:1] == 6'h00)
		else $error("shareability or reserved bits wrong");

	sec_share_a: assert property (upd_ok[1] |=> result[1][8:7] == $past(xlat.shareability_field)
		&& result[1][6:0] == 7'h00)
		else $error("secure shareability or low bits wrong");

	impl_bit_a: assert property (upd_ok[0] |=> result[0][10] == $past(xlat.impl_defined_bit))
		else $error("implementation bit not reported");

	success_clear_a: assert property (upd_ok[0] || upd_ok[1] |=> result[$past(xlat.bank_secure)][0] == 1'b0)
		else $error("fault bit set on success");

	// Secure result stands until the next translation for the secure copy
	result_hold_a: assert property (!(xlat.done && xlat.bank_secure) |=> $stable(result[1]))
		else $error("secure result changed without a translation");

	// ==========================================
	// Fault layout, both copies
	fault_layout_a: assert property (upd_fault[1] |=> result[1][0] && result[1][63:34] == 30'h0000_0000
		&& result[1][33:32] == $past(xlat.walk_level))
		else $error("fault layout or walk level wrong");

	ns_fault_level_a: assert property (upd_fault[0] |=> result[0][0] && result[0][33:32] == $past(xlat.walk_level)
		&& result[0][31] == 1'b0 && result[0][28:7] == 22'h00_0000)
		else $error("non-secure fault layout wrong");

	fault_flags_a: assert property (upd_fault[0] |=> result[0][30] == $past(xlat.missing_bank_fault)
		&& result[0][29] == $past(xlat.invalid_context_flag) && result[0][6] == $past(xlat.lock_fault_flag)
		&& result[0][5] == $past(xlat.multi_match_fault) && result[0][4] == $past(xlat.external_fault_flag)
		&& result[0][3] == $past(xlat.permission_fault_flag) && result[0][2] == $past(xlat.access_flag_error)
		&& result[0][1] == $past(xlat.mapping_fault_flag))
		else $error("fault flags not reported");

	sec_fault_flags_a: assert property (upd_fault[1] |=> result[1][30] == $past(xlat.missing_bank_fault)
		&& result[1][29] == $past(xlat.invalid_context_flag) && result[1][6] == $past(xlat.lock_fault_flag)
		&& result[1][5] == $past(xlat.multi_match_fault) && result[1][4] == $past(xlat.external_fault_flag)
		&& result[1][3] == $past(xlat.permission_fault_flag) && result[1][2] == $past(xlat.access_flag_error)
		&& result[1][1] == $past(xlat.mapping_fault_flag))
		else $error("secure fault flags not reported");

	// ==========================================
	// Sync command routing; the other copy may still finish its own drain
	sync_start_a: assert property (secure_cmd_s |=> active[1] && ($past(active[0]) || !active[0]))
		else $error("secure sync command did not start secure sync");

	ns_start_a: assert property (ns_cmd_s |=> active[0] && ($past(active[1]) || !active[1]))
		else $error("non-secure sync command routed wrongly");

	alias_start_a: assert property (alias_cmd_s |=> active[0])
		else $error("alias command did not start non-secure sync");

	alias_refused_a: assert property (ns_alias_s ##0 !active[0] |=> !active[0])
		else $error("non-secure master reached the alias");

	idle_stays_a: assert property (!active[1] && !cmd_hit[1] |=> !active[1])
		else $error("sync started without a command");

	sync_end_a: assert property (active[1] && drain[1] == '0 && !cmd_hit[1] |=> !active[1])
		else $error("sync stayed active with nothing to drain");

	sync_hold_a: assert property (active[0] && drain[0] != '0 |=> active[0])
		else $error("sync ended before earlier invalidates finished");

	// ==========================================
	// Drain bookkeeping
	snapshot_a: assert property (cmd_hit[1] && !inval.done[1] |=> drain[1] == $past(pending[1]))
		else $error("sync did not take all earlier invalidates");

	drain_step_a: assert property (active[0] && drain[0] != '0 && inval.done[0] && !cmd_hit[0]
		|=> drain[0] == $past(drain[0]) - PEND_W'(1))
		else $error("completion not counted out of the drain");

	pending_up_a: assert property (inval.start[1] && !inval.done[1] |=> pending[1] == $past(pending[1]) + PEND_W'(1))
		else $error("accepted invalidate not counted");

	stray_done_a: assert property (inval.done[0] && !inval.start[0] && pending[0] == '0 |=> pending[0] == '0)
		else $error("stray completion changed the count");

	// ==========================================
	// Bus and observers
	wait_one_a: assert property (!waitrequest |=> waitrequest) // One acknowledge per request
		else $error("acknowledge lasted more than one cycle");

	busy_follow_a: assert property (cmd_hit[1] |=> sync_busy[1])
		else $error("busy output missed a secure command");

	status_read_a: assert property (status_read_s ##1 !waitrequest |-> readdata[31:1] == 31'h0000_0000
		&& readdata[0] == $past(own_active))
		else $error("status read returned wrong value");

endmodule

// File: verif/test_translation_result_tlb_sync.sv
// Self-checking bench for the translation result and TLB sync block
`timescale 1ns/1ps
`include "tlb_sync_regs.svh"
module test_translation_result_tlb_sync
	import tlb_sync_pkg::*;
;
	// ==========================================
	// Signals
	logic clock;
	logic rstn;
	bus_req_t bus_req;
	logic bus_secure;
	logic [31:0] readdata;
	logic waitrequest;
	xlat_result_t xlat;
	inval_event_t inval;
	logic [1:0] sync_busy;
	int fail_count;
	int checks_done;
	logic [31:0] v;

	translation_result_tlb_sync i_dut (.clock(clock), .rstn(rstn), .bus_req(bus_req), .bus_secure(bus_secure),
		.readdata(readdata), .waitrequest(waitrequest), .xlat(xlat), .inval(inval), .sync_busy(sync_busy));

	// ==========================================
	// Clock, 20 ns period
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Compare one 32-bit result
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One Avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic sec, input logic [7:0] addr, output logic [31:0] rd);
		@(posedge clock);
		bus_req.read <= !wr;
		bus_req.write <= wr;
		bus_req.address <= addr;
		bus_req.writedata <= 32'h0000_0000;
		bus_req.byteenable <= 4'hF;
		bus_secure <= sec;
		// Only the watchdog ends a wait that never gets an answer
		do
		begin
			@(posedge clock);
		end
		while (waitrequest !== 1'b0);
		rd = readdata;
		bus_req.read <= 1'b0;
		bus_req.write <= 1'b0;
	endtask

	// Read and compare
	task automatic rd_chk(input string name, input logic sec, input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, sec, addr, d);
		check(name, exp, d);
	endtask

	// Walker result pulse
	task automatic post(input xlat_result_t x);
		@(posedge clock);
		xlat <= x;
		@(posedge clock);
		xlat.done <= 1'b0;
	endtask

	// Invalidate event pulse
	task automatic ev(input logic [1:0] st, input logic [1:0] dn);
		@(posedge clock);
		inval <= '{start: st, done: dn};
		@(posedge clock);
		inval <= '0;
	endtask

	// ==========================================
	// Scenarios
	task automatic test_reset();
		rd_chk("status s", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0000);
		rd_chk("status ns", 1'b0, `OFF_SYNC_STATUS, 32'h0000_0000);
		rd_chk("result lo", 1'b1, `OFF_RESULT_LO, 32'h0000_0000);
		rd_chk("unmapped", 1'b1, 8'h40, 32'h0000_0000);
		bus(1'b1, 1'b1, `OFF_SYNC_STATUS, v);
		rd_chk("status ro", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0000);
	endtask

	task automatic test_success();
		xlat_result_t x;
		logic [63:0] e;
		logic [63:0] e2;
		x = '0;
		x.done = 1'b1;
		x.bank_secure = 1'b1;
		x.result_memory_attributes = 8'hA5;
		x.physical_address_field = 28'h9AB_CDE1;
		x.security_attribute_bit = 1'b1;
		x.shareability_field = 2'b10;
		e = {x.result_memory_attributes, 16'h0000, x.physical_address_field, 2'b00, 1'b1, 2'b10, 7'h00};
		post(x);
		// Bit 10 is implementation defined, so it is masked
		bus(1'b0, 1'b1, `OFF_RESULT_LO, v);
		check("ok lo s", e[31:0], v & ~32'h0000_0400);
		rd_chk("ok hi s", 1'b1, `OFF_RESULT_HI, e[63:32]);
		x.bank_secure = 1'b0;
		x.result_memory_attributes = 8'h3C;
		x.shareability_field = 2'b01;
		e2 = {8'h3C, 16'h0000, x.physical_address_field, 2'b00, 1'b0, 2'b01, 7'h00};
		post(x);
		bus(1'b0, 1'b0, `OFF_RESULT_LO, v);
		check("ok lo ns", e2[31:0], v & ~32'h0000_0400);
		rd_chk("ok hi ns", 1'b0, `OFF_RESULT_HI, e2[63:32]);
		bus(1'b0, 1'b1, `OFF_RESULT_LO, v);
		check("ok lo kept", e[31:0], v & ~32'h0000_0400);
	endtask

	task automatic test_fault();
		xlat_result_t x;
		logic [63:0] e;
		logic [7:0] p;
		for (int i = 0; i < 3; i++)
		begin
			p = (i == 0) ? 8'hA5 : (i == 1) ? 8'h5A : 8'hFF;
			x = '1;
			x.bank_secure = (i != 2);
			x.walk_level = 2'(i + 1);
			{x.missing_bank_fault, x.invalid_context_flag, x.lock_fault_flag, x.multi_match_fault} = p[7:4];
			{x.external_fault_flag, x.permission_fault_flag, x.access_flag_error, x.mapping_fault_flag} = p[3:0];
			e = {30'h0000_0000, x.walk_level, 1'b0, p[7:6], 22'h00_0000, p[5:0], 1'b1};
			post(x);
			rd_chk("fault lo", i != 2, `OFF_RESULT_LO, e[31:0]);
			rd_chk("fault hi", i != 2, `OFF_RESULT_HI, e[63:32]);
		end
	endtask

	task automatic test_sync();
		ev(2'b10, 2'b00);
		ev(2'b11, 2'b00);
		bus(1'b1, 1'b1, `OFF_SYNC_COMMAND, v);
		rd_chk("sync s on", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0001);
		rd_chk("sync ns idle", 1'b0, `OFF_SYNC_STATUS, 32'h0000_0000);
		check("busy mid", 32'h0000_0002, {30'h0000_0000, sync_busy});
		ev(2'b00, 2'b10);
		rd_chk("sync s one", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0001);
		ev(2'b00, 2'b10);
		rd_chk("sync s done", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0000);
	endtask

	task automatic test_alias();
		bus(1'b1, 1'b1, `OFF_ALIAS_COMMAND, v);
		rd_chk("ns on", 1'b0, `OFF_SYNC_STATUS, 32'h0000_0001);
		rd_chk("alias on", 1'b1, `OFF_ALIAS_STATUS, 32'h0000_0001);
		rd_chk("alias ns", 1'b0, `OFF_ALIAS_STATUS, 32'h0000_0000);
		rd_chk("s idle", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0000);
		ev(2'b00, 2'b01);
		rd_chk("alias off", 1'b1, `OFF_ALIAS_STATUS, 32'h0000_0000);
		bus(1'b1, 1'b0, `OFF_SYNC_COMMAND, v);
		rd_chk("ns empty", 1'b0, `OFF_SYNC_STATUS, 32'h0000_0000);
	endtask

	// Software flow: command, then poll status, finishing the invalidate while it reads busy
	task automatic test_poll();
		int polls;
		ev(2'b10, 2'b00);
		bus(1'b1, 1'b1, `OFF_SYNC_COMMAND, v);
		polls = 0;
		do
		begin
			bus(1'b0, 1'b1, `OFF_SYNC_STATUS, v);
			polls++;
			if (v[0] === 1'b1)
				ev(2'b00, 2'b10);
		end
		while (v !== 32'h0000_0000 && polls < 8);
		check("poll status", 32'h0000_0000, v);
		check("poll reads", 32'h0000_0002, 32'(polls));
	endtask

	// Reset in mid-run drops a running sync and the invalidate count
	task automatic test_reset_mid();
		ev(2'b10, 2'b00);
		bus(1'b1, 1'b1, `OFF_SYNC_COMMAND, v);
		rd_chk("status before reset", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0001);
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		rd_chk("status after reset", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0000);
		rd_chk("result after reset", 1'b0, `OFF_RESULT_LO, 32'h0000_0000);
		bus(1'b1, 1'b1, `OFF_SYNC_COMMAND, v);
		rd_chk("drain after reset", 1'b1, `OFF_SYNC_STATUS, 32'h0000_0000);
	endtask

	// ==========================================
	// Verdict and end of run
	task automatic results();
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog: whole run needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clock);
		fail_count++;
		results();
	end

	// Main sequence
	initial
	begin
		fail_count = 0;
		checks_done = 0;
		rstn = 1'b0;
		bus_req = '0;
		bus_secure = 1'b0;
		xlat = '0;
		inval = '0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		test_reset();
		test_success();
		test_fault();
		test_sync();
		test_alias();
		test_poll();
		test_reset_mid();
		results();
	end
endmodule
